/* hdl/cmd_dec_if.sv */
/*
 Carrier between the parser and the opcode table.
 Assumes one clock domain; all signals are combinational.
*/
`timescale 1ns/100ps
interface cmd_dec_if;
	import cmd_pkg::*;
	logic esc; // Two-byte opcode page
	logic [7:0] opcode; // Opcode byte
	logic [1:0] modf; // Addressing mode field
	logic [2:0] reg_f; // Reg field of addressing byte
	logic op32; // 32-bit operand size
	logic [4:0] div_extra; // Early-exit count from operand path
	logic need_modrm; // Opcode takes an addressing byte
	logic has_imm; // Immediate follows
	logic legal; // Known encoding
	cmd_class_type cls; // Decoded class
	logic [5:0] cycles; // Execution clocks
	logic [5:0] fl_mod; // Flags modified
	logic [5:0] fl_undef; // Flags left undefined
	modport parser (output esc, opcode, modf, reg_f, op32, div_extra,
		input need_modrm, has_imm, legal, cls, cycles, fl_mod, fl_undef);
	modport table_side (input esc, opcode, modf, reg_f, op32, div_extra,
		output need_modrm, has_imm, legal, cls, cycles, fl_mod, fl_undef);
endinterface

/* hdl/cmd_decoder.sv */
/*
 Byte-stream decoder and timing unit for conditional moves,
 compare-and-swap, sign extension, BCD fixes, decrement and divide.
 Assumes bytes come from fetch logic on core_clk, flags and the divide
 early-exit count from the operand pipeline on the same clock.
*/
`timescale 1ns/100ps
`include "cmd_params.svh"

// How it works
// - 0F 40 and 0F 41 move when overflow is set or clear, in 1 clock.
// - 0F 4A moves only when parity is set, in 1 clock.
// - 0F 4B moves only when parity is clear, in 1 clock.
// - 0F 48 moves only when sign is set, in 1 clock.
// - 0F 49 moves only when sign is clear, in 1 clock.
// - 0F B0 and 0F B1 compare-and-swap take 11 clocks and set flags.
// - 0F C7 with reg 001 and a memory operand is the 8-byte swap.
// - Opcode 99 extends the accumulator into the pair in 2 clocks.
// - Opcode 98 extends the low accumulator word in 2 clocks.
// - Opcode 27 fixes BCD after add, sets flags, takes 9 clocks.
// - Opcode 2F fixes BCD after subtract, sets flags, takes 9 clocks.
// - Decrement is FE/FF reg 001 or 48-4F, 1 clock, carry untouched.
// - F6/F7 reg 110 divides in 13-17, 13-25 or 13-41 clocks.
// - An immediate is 8, 16 or 32 bits wide by operand size.
// - A short displacement is 8 bits and sign-extended.
// - A conditional move takes 1 clock whether or not it moves.
module cmd_decoder import cmd_pkg::*; #(
	parameter logic [5:0] CYC_SWAP_QUAD = `CMD_CYC_SWAP
) (
	input wire logic core_clk, // Core clock, 20 MHz
	input wire logic rst, // Async reset, high
	input wire logic fetch_valid, // Byte offered
	input wire logic [7:0] fetch_byte, // Instruction byte
	input wire logic op32, // 32-bit operand and address size
	input wire logic flag_of, // Overflow flag
	input wire logic flag_sf, // Sign flag
	input wire logic flag_pf, // Parity flag
	input wire logic [4:0] div_extra, // Divide early-exit clocks
	output logic fetch_ready, // Byte will be taken
	output logic done, // Instruction complete, one pulse
	output logic [3:0] op_class, // Decoded class
	output logic move_en, // Destination write enable
	output logic illegal, // Unknown encoding
	output logic [7:0] modrm, // Addressing byte
	output logic [31:0] disp, // Displacement, sign-extended
	output logic [31:0] imm, // Immediate, zero-extended
	output logic [5:0] flags_mod, // Flags written: OF SF ZF AF PF CF
	output logic [5:0] flags_undef // Flags left undefined
);
	cmd_dec_if dec ();
	cmd_state_type st_ff, nxt_st;
	logic esc_ff, nxt_esc;
	logic [7:0] op_ff, nxt_op;
	logic [7:0] modrm_ff, nxt_modrm;
	logic [31:0] disp_ff, nxt_disp;
	logic [31:0] imm_ff, nxt_imm;
	logic [2:0] len_ff, nxt_len;
	logic [1:0] idx_ff, nxt_idx;
	logic short_ff, nxt_short;
	logic ready_ff, nxt_ready;
	logic done_ff, nxt_done;
	logic [3:0] class_ff, nxt_class;
	logic move_ff, nxt_move;
	logic illegal_ff, nxt_illegal;
	logic [5:0] fmod_ff, nxt_fmod;
	logic [5:0] fund_ff, nxt_fund;
	logic cond_ok;
	logic take;
	logic load;
	logic finish;
	logic [2:0] dlen;
	logic [2:0] ilen;

	cmd_opcode_table #(
		.CYC_SWAP_QUAD(CYC_SWAP_QUAD)
	) u_table (
		.d(dec.table_side)
	);

	cmd_exec_timer #(
		.W(6)
	) u_timer (
		.core_clk(core_clk),
		.rst(rst),
		.load(load),
		.cycles(dec.cycles),
		.finish(finish)
	);

	assign take = fetch_valid && ready_ff;

	// Table inputs follow the byte in flight while it is being parsed
	always_comb begin
		// A first byte uses the one-byte page, not the last opcode's page
		dec.esc = (st_ff == ST_ESC) ? 1'b1 :
			(st_ff == ST_OP) ? 1'b0 : esc_ff;
		dec.opcode = (st_ff == ST_OP || st_ff == ST_ESC) ?
			fetch_byte : op_ff;
		dec.modf = (st_ff == ST_MODRM) ? fetch_byte[7:6] : modrm_ff[7:6];
		dec.reg_f = (st_ff == ST_MODRM) ? fetch_byte[5:3] : modrm_ff[5:3];
		dec.op32 = op32;
		dec.div_extra = div_extra;
	end

	// Displacement length from the addressing byte
	always_comb begin
		dlen = 3'h0;
		if (op32) begin
			if (fetch_byte[7:6] == 2'h1)
				dlen = 3'h1;
			else if (fetch_byte[7:6] == 2'h2)
				dlen = 3'h4;
			else if (fetch_byte[7:6] == 2'h0 && fetch_byte[2:0] == 3'h5)
				dlen = 3'h4;
		end else begin
			if (fetch_byte[7:6] == 2'h1)
				dlen = 3'h1;
			else if (fetch_byte[7:6] == 2'h2)
				dlen = 3'h2;
			else if (fetch_byte[7:6] == 2'h0 && fetch_byte[2:0] == 3'h6)
				dlen = 3'h2;
		end
		// Immediate width by operand size
		if (!op_ff[0])
			ilen = 3'h1;
		else
			ilen = op32 ? 3'h4 : 3'h2;
	end

	// Condition of the conditional moves, sampled at completion
	always_comb begin
		unique case (class_ff)
			CL_MOVE_IF_OVERFLOW: cond_ok = flag_of;
			CL_MOVE_IF_NO_OVERFLOW: cond_ok = !flag_of;
			CL_MOVE_IF_PARITY_EVEN: cond_ok = flag_pf;
			CL_MOVE_IF_PARITY_ODD: cond_ok = !flag_pf;
			CL_MOVE_IF_NEGATIVE: cond_ok = flag_sf;
			CL_MOVE_IF_POSITIVE: cond_ok = !flag_sf;
			default: cond_ok = 1'b0;
		endcase
	end

	// Parser and completion
	always_comb begin
		nxt_st = st_ff;
		nxt_esc = esc_ff;
		nxt_op = op_ff;
		nxt_modrm = modrm_ff;
		nxt_disp = disp_ff;
		nxt_imm = imm_ff;
		nxt_len = len_ff;
		nxt_idx = idx_ff;
		nxt_short = short_ff;
		nxt_done = 1'b0;
		nxt_class = class_ff;
		nxt_move = 1'b0;
		nxt_illegal = illegal_ff;
		nxt_fmod = fmod_ff;
		nxt_fund = fund_ff;
		load = 1'b0;
		unique case (st_ff)
			ST_OP: if (take) begin
				nxt_op = fetch_byte;
				nxt_esc = 1'b0;
				nxt_disp = 32'h00000000;
				nxt_imm = 32'h00000000;
				nxt_modrm = 8'h00;
				if (fetch_byte == `CMD_OP_ESC)
					nxt_st = ST_ESC;
				else if (dec.need_modrm)
					nxt_st = ST_MODRM;
				else
					load = 1'b1;
			end
			ST_ESC: if (take) begin
				nxt_op = fetch_byte;
				nxt_esc = 1'b1;
				if (dec.need_modrm)
					nxt_st = ST_MODRM;
				else
					load = 1'b1;
			end
			ST_MODRM: if (take) begin
				nxt_modrm = fetch_byte;
				nxt_idx = 2'h0;
				nxt_len = dlen;
				nxt_short = (fetch_byte[7:6] == 2'h1);
				if (op32 && fetch_byte[7:6] != 2'h3 &&
					fetch_byte[2:0] == 3'h4)
					nxt_st = ST_SIB;
				else if (dlen != 3'h0)
					nxt_st = ST_DISP;
				else if (dec.has_imm && dec.legal) begin
					nxt_len = ilen;
					nxt_st = ST_IMM;
				end else
					load = 1'b1;
			end
			ST_SIB: if (take) begin
				// Base 101 without mode adds a full displacement
				if (modrm_ff[7:6] == 2'h0 && fetch_byte[2:0] == 3'h5)
					nxt_len = 3'h4;
				if (nxt_len != 3'h0)
					nxt_st = ST_DISP;
				else if (dec.has_imm && dec.legal) begin
					nxt_len = ilen;
					nxt_st = ST_IMM;
				end else
					load = 1'b1;
			end
			ST_DISP: if (take) begin
				nxt_disp[{idx_ff, 3'h0} +: 8] = fetch_byte;
				nxt_idx = idx_ff + 2'h1;
				if ({1'b0, idx_ff} == len_ff - 3'h1) begin
					if (short_ff)
						nxt_disp = {{24{fetch_byte[7]}}, fetch_byte};
					else if (len_ff == 3'h2)
						nxt_disp = {{16{fetch_byte[7]}}, fetch_byte,
							disp_ff[7:0]};
					nxt_idx = 2'h0;
					if (dec.has_imm && dec.legal) begin
						nxt_len = ilen;
						nxt_st = ST_IMM;
					end else
						load = 1'b1;
				end
			end
			ST_IMM: if (take) begin
				nxt_imm[{idx_ff, 3'h0} +: 8] = fetch_byte;
				nxt_idx = idx_ff + 2'h1;
				if ({1'b0, idx_ff} == len_ff - 3'h1)
					load = 1'b1;
			end
			ST_EXEC: if (finish) begin
				// Move decision taken as the clock count ends
				nxt_done = 1'b1;
				nxt_move = cond_ok;
				nxt_st = ST_OP;
			end
			default: nxt_st = ST_OP;
		endcase
		// Latch the decoded result as the last byte is taken
		if (load) begin
			nxt_st = ST_EXEC;
			nxt_class = dec.legal ? dec.cls : CL_NONE;
			nxt_illegal = !dec.legal;
			nxt_fmod = dec.legal ? dec.fl_mod : `CMD_FL_NONE;
			nxt_fund = dec.legal ? dec.fl_undef : `CMD_FL_NONE;
		end
		// No new byte while an instruction executes
		nxt_ready = (nxt_st != ST_EXEC);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_ff <= ST_OP;
			esc_ff <= 1'b0;
			op_ff <= 8'h00;
			modrm_ff <= 8'h00;
			disp_ff <= 32'h00000000;
			imm_ff <= 32'h00000000;
			len_ff <= 3'h0;
			idx_ff <= 2'h0;
			short_ff <= 1'b0;
			ready_ff <= 1'b0;
			done_ff <= 1'b0;
			class_ff <= 4'h0;
			move_ff <= 1'b0;
			illegal_ff <= 1'b0;
			fmod_ff <= 6'h00;
			fund_ff <= 6'h00;
		end else begin
			st_ff <= nxt_st;
			esc_ff <= nxt_esc;
			op_ff <= nxt_op;
			modrm_ff <= nxt_modrm;
			disp_ff <= nxt_disp;
			imm_ff <= nxt_imm;
			len_ff <= nxt_len;
			idx_ff <= nxt_idx;
			short_ff <= nxt_short;
			ready_ff <= nxt_ready;
			done_ff <= nxt_done;
			class_ff <= nxt_class;
			move_ff <= nxt_move;
			illegal_ff <= nxt_illegal;
			fmod_ff <= nxt_fmod;
			fund_ff <= nxt_fund;
		end
	end

	// Outputs straight from flops
	assign fetch_ready = ready_ff;
	assign done = done_ff;
	assign op_class = class_ff;
	assign move_en = move_ff;
	assign illegal = illegal_ff;
	assign modrm = modrm_ff;
	assign disp = disp_ff;
	assign imm = imm_ff;
	assign flags_mod = fmod_ff;
	assign flags_undef = fund_ff;
endmodule

/* hdl/cmd_exec_timer.sv */
/*
 Execution timer: counts the clocks of one instruction.
 Assumes load arrives only while idle.
*/
`timescale 1ns/100ps
module cmd_exec_timer #(
	parameter int W = 6
) (
	input wire logic core_clk, // Core clock
	input wire logic rst, // Async reset, high
	input wire logic load, // Start counting
	input wire logic [W-1:0] cycles, // Clocks to count, at least 1
	output logic finish // High in the last counted clock
);
	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;

	// Down count to zero
	always_comb begin
		nxt_cnt = cnt_ff;
		if (load)
			nxt_cnt = cycles;
		else if (cnt_ff != '0)
			nxt_cnt = cnt_ff - W'(1);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			cnt_ff <= '0;
		else
			cnt_ff <= nxt_cnt;
	end

	assign finish = (cnt_ff == W'(1));
endmodule

/* hdl/cmd_opcode_table.sv */
/*
 Opcode table: class, cycle count and flag effects per encoding.
 Assumes reg and mode fields are valid once an addressing byte is seen.
*/
`timescale 1ns/100ps
`include "cmd_params.svh"
module cmd_opcode_table import cmd_pkg::*; #(
	parameter logic [5:0] CYC_SWAP_QUAD = `CMD_CYC_SWAP
) (
	cmd_dec_if.table_side d // Lookup request and answer
);
	logic [5:0] extra;
	logic [5:0] limit;

	// Divide early exit, capped by divisor size
	always_comb begin
		extra = {1'b0, d.div_extra};
		if (!d.opcode[0])
			limit = `CMD_DIV_EXTRA_B;
		else if (d.op32)
			limit = `CMD_DIV_EXTRA_D;
		else
			limit = `CMD_DIV_EXTRA_W;
		if (extra > limit)
			extra = limit;
	end

	// Table lookup
	always_comb begin
		d.need_modrm = 1'b0;
		d.has_imm = 1'b0;
		d.legal = 1'b1;
		d.cls = CL_NONE;
		d.cycles = `CMD_CYC_OTHER;
		d.fl_mod = `CMD_FL_NONE;
		d.fl_undef = `CMD_FL_NONE;
		if (d.esc) begin
			d.need_modrm = 1'b1;
			unique case (d.opcode)
				`CMD_OP_MOV_OV: d.cls = CL_MOVE_IF_OVERFLOW;
				`CMD_OP_MOV_NOV: d.cls = CL_MOVE_IF_NO_OVERFLOW;
				`CMD_OP_MOV_PE: d.cls = CL_MOVE_IF_PARITY_EVEN;
				`CMD_OP_MOV_PO: d.cls = CL_MOVE_IF_PARITY_ODD;
				`CMD_OP_MOV_NEG: d.cls = CL_MOVE_IF_NEGATIVE;
				`CMD_OP_MOV_POS: d.cls = CL_MOVE_IF_POSITIVE;
				`CMD_OP_SWAPQ_PAGE: begin
					d.cls = CL_COMPARE_SWAP_QUAD;
					d.cycles = CYC_SWAP_QUAD;
					// Memory operand only
					d.legal = (d.reg_f == `CMD_REG_SWAPQ) &&
						(d.modf != 2'h3);
				end
				default: begin
					if (d.opcode[7:1] == `CMD_OP_SWAP_HI7) begin
						d.cls = CL_COMPARE_SWAP;
						d.cycles = `CMD_CYC_SWAP;
						d.fl_mod = `CMD_FL_ARITH;
					end else begin
						d.legal = 1'b0;
						d.need_modrm = 1'b0;
					end
				end
			endcase
			// Refused encodings finish in the single default clock
			if (!d.legal)
				d.cycles = `CMD_CYC_OTHER;
			else if (d.cls != CL_COMPARE_SWAP &&
				d.cls != CL_COMPARE_SWAP_QUAD)
				d.cycles = `CMD_CYC_MOVE;
		end else begin
			unique case (d.opcode)
				`CMD_OP_EXT_PAIR: begin
					d.cls = CL_SIGN_EXTEND_TO_PAIR;
					d.cycles = `CMD_CYC_EXT;
				end
				`CMD_OP_EXT_ACC: begin
					d.cls = CL_SIGN_EXTEND_ACC;
					d.cycles = `CMD_CYC_EXT;
				end
				`CMD_OP_BCD_ADD, `CMD_OP_BCD_SUB: begin
					d.cls = d.opcode[3] ? CL_BCD_FIX_AFTER_SUB :
						CL_BCD_FIX_AFTER_ADD;
					d.cycles = `CMD_CYC_BCD;
					d.fl_mod = `CMD_FL_BCD;
					d.fl_undef = `CMD_FL_OF;
				end
				default: begin
					if (d.opcode[7:3] == `CMD_OP_DEC_HI5) begin
						d.cls = CL_DECREMENT_OP;
						d.cycles = `CMD_CYC_DEC;
						d.fl_mod = `CMD_FL_NO_CF;
					end else if (d.opcode[7:1] == `CMD_OP_GRP5_HI7) begin
						d.need_modrm = 1'b1;
						d.legal = (d.reg_f == `CMD_REG_DEC);
						d.cls = CL_DECREMENT_OP;
						d.cycles = `CMD_CYC_DEC;
						d.fl_mod = `CMD_FL_NO_CF;
					end else if (d.opcode[7:1] == `CMD_OP_GRP3_HI7) begin
						d.need_modrm = 1'b1;
						if (d.reg_f == `CMD_REG_DIV) begin
							d.cls = CL_DIVIDE_UNSIGNED;
							d.cycles = `CMD_CYC_DIV_BASE + extra;
							d.fl_undef = `CMD_FL_NO_CF;
						end else if (d.reg_f == `CMD_REG_TEST) begin
							d.cls = CL_TEST_IMM;
							d.has_imm = 1'b1;
							d.fl_mod = `CMD_FL_ARITH;
						end else
							d.legal = 1'b0;
					end else
						d.legal = 1'b0;
				end
			endcase
		end
	end
endmodule

/* hdl/cmd_params.svh */
/*
 Opcode values, cycle counts and field positions for the decoder.
 Assumes inclusion by bare name from every file that needs them.
*/
`ifndef CMD_PARAMS_SVH
`define CMD_PARAMS_SVH

// Opcode bytes
`define CMD_OP_ESC 8'h0F
`define CMD_OP_MOV_OV 8'h40
`define CMD_OP_MOV_NOV 8'h41
`define CMD_OP_MOV_NEG 8'h48
`define CMD_OP_MOV_POS 8'h49
`define CMD_OP_MOV_PE 8'h4A
`define CMD_OP_MOV_PO 8'h4B
`define CMD_OP_SWAP_HI7 7'h58
`define CMD_OP_SWAPQ 8'h07
`define CMD_OP_SWAPQ_PAGE 8'hC7
`define CMD_OP_EXT_PAIR 8'h99
`define CMD_OP_EXT_ACC 8'h98
`define CMD_OP_BCD_ADD 8'h27
`define CMD_OP_BCD_SUB 8'h2F
`define CMD_OP_DEC_HI5 5'h09
`define CMD_OP_GRP3_HI7 7'h7B
`define CMD_OP_GRP5_HI7 7'h7F
`define CMD_REG_DEC 3'h1
`define CMD_REG_DIV 3'h6
`define CMD_REG_TEST 3'h0
`define CMD_REG_SWAPQ 3'h1

// Cycle counts, register or cache-hit operands
`define CMD_CYC_MOVE 6'h01
`define CMD_CYC_SWAP 6'h0B
`define CMD_CYC_EXT 6'h02
`define CMD_CYC_BCD 6'h09
`define CMD_CYC_DEC 6'h01
`define CMD_CYC_DIV_BASE 6'h0D
`define CMD_DIV_EXTRA_B 6'h04
`define CMD_DIV_EXTRA_W 6'h0C
`define CMD_DIV_EXTRA_D 6'h1C
`define CMD_CYC_OTHER 6'h01

// Flag vector bit order: OF SF ZF AF PF CF
`define CMD_FL_ARITH 6'h3F
`define CMD_FL_NO_CF 6'h3E
`define CMD_FL_BCD 6'h1F
`define CMD_FL_OF 6'h20
`define CMD_FL_NONE 6'h00

`endif

/* hdl/cmd_pkg.sv */
/*
 Types shared by the decoder modules.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package cmd_pkg;

	// Parse states, one-hot
	typedef enum logic [6:0] {
		ST_OP = 7'h01,
		ST_ESC = 7'h02,
		ST_MODRM = 7'h04,
		ST_SIB = 7'h08,
		ST_DISP = 7'h10,
		ST_IMM = 7'h20,
		ST_EXEC = 7'h40
	} cmd_state_type;

	// Decoded instruction class
	typedef enum logic [3:0] {
		CL_NONE = 4'h0,
		CL_MOVE_IF_OVERFLOW = 4'h1,
		CL_MOVE_IF_NO_OVERFLOW = 4'h2,
		CL_MOVE_IF_PARITY_EVEN = 4'h3,
		CL_MOVE_IF_PARITY_ODD = 4'h4,
		CL_MOVE_IF_NEGATIVE = 4'h5,
		CL_MOVE_IF_POSITIVE = 4'h6,
		CL_COMPARE_SWAP = 4'h7,
		CL_COMPARE_SWAP_QUAD = 4'h8,
		CL_SIGN_EXTEND_TO_PAIR = 4'h9,
		CL_SIGN_EXTEND_ACC = 4'hA,
		CL_BCD_FIX_AFTER_ADD = 4'hB,
		CL_BCD_FIX_AFTER_SUB = 4'hC,
		CL_DECREMENT_OP = 4'hD,
		CL_DIVIDE_UNSIGNED = 4'hE,
		CL_TEST_IMM = 4'hF
	} cmd_class_type;

endpackage

/* verification/cmd_decoder_chk.sv */
/*
 Timing and flag checks on the decoder's completion outputs.
 Assumes it is bound onto cmd_decoder and sees only its ports.
*/
`timescale 1ns/100ps
module cmd_decoder_chk #(
	parameter logic [5:0] CYC_SWAP_QUAD = 6'h0B
) (
	input wire logic core_clk, // Core clock
	input wire logic rst, // Async reset, high
	input wire logic fetch_valid, // Byte offered
	input wire logic [7:0] fetch_byte, // Instruction byte
	input wire logic op32, // Operand size
	input wire logic flag_of, // Overflow flag
	input wire logic flag_sf, // Sign flag
	input wire logic flag_pf, // Parity flag
	input wire logic [4:0] div_extra, // Divide extra clocks
	input wire logic fetch_ready, // Byte will be taken
	input wire logic done, // Completion pulse
	input wire logic [3:0] op_class, // Decoded class
	input wire logic move_en, // Destination write
	input wire logic illegal, // Unknown encoding
	input wire logic [7:0] modrm, // Addressing byte
	input wire logic [31:0] disp, // Displacement
	input wire logic [31:0] imm, // Immediate
	input wire logic [5:0] flags_mod, // Flags written
	input wire logic [5:0] flags_undef // Flags undefined
);
	logic seen_ff, rdy_q_ff, nxt_seen, nxt_rdy;
	logic [5:0] cnt_ff, nxt_cnt;
	// Count clocks from the fall of ready, so done shows the exec length
	always_comb begin
		nxt_seen = seen_ff | fetch_ready;
		nxt_rdy = fetch_ready;
		nxt_cnt = (rdy_q_ff && !fetch_ready) ? 6'h01 : cnt_ff + 6'h01;
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			seen_ff <= 1'b0;
			rdy_q_ff <= 1'b0;
			cnt_ff <= 6'h00;
		end else begin
			seen_ff <= nxt_seen;
			rdy_q_ff <= nxt_rdy;
			cnt_ff <= nxt_cnt;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	a_done_pulse: assert property (done |=> !done)
		else $error("done too long");
	a_stall_bound: assert property (
		seen_ff && !fetch_ready |-> ##[0:41] done)
		else $error("stall too long");
	a_one_clock: assert property (
		done && op_class inside {[4'h0:4'h6], 4'hD, 4'hF} |->
		cnt_ff == 6'h01) else $error("not 1 clock");
	a_swap_time: assert property (
		done && op_class == 4'h7 |-> cnt_ff == 6'h0B)
		else $error("swap count");
	a_quad_time: assert property (
		done && op_class == 4'h8 |-> cnt_ff == CYC_SWAP_QUAD)
		else $error("quad count");
	a_ext_time: assert property (
		done && op_class inside {4'h9, 4'hA} |-> cnt_ff == 6'h02)
		else $error("extend count");
	a_bcd_time: assert property (
		done && op_class inside {4'hB, 4'hC} |->
		cnt_ff == 6'h09 && flags_mod == 6'h1F) else $error("bcd");
	a_div_time: assert property (
		done && op_class == 4'hE |->
		cnt_ff inside {[6'h0D:6'h29]} && flags_undef == 6'h3E)
		else $error("divide");
	a_move_cmov: assert property (
		move_en |-> done && op_class inside {[4'h1:4'h6]})
		else $error("stray move");
	a_dec_flags: assert property (
		done && op_class == 4'hD |-> flags_mod == 6'h3E)
		else $error("dec flags");
	a_swap_flags: assert property (
		done && op_class == 4'h7 |-> flags_mod == 6'h3F)
		else $error("swap flags");
	c_move: cover property (move_en);
	c_divide: cover property (done && op_class == 4'hE);
	c_illegal: cover property (done && illegal);
endmodule

/* verification/cmd_fetch_model.sv */
/*
 Fetch-side model: offers queued instruction bytes to the decoder.
 Assumes the bench pushes bytes into q and sets gap for slow fetch.
*/
`timescale 1ns/100ps
module cmd_fetch_model (
	input wire logic core_clk, // Core clock
	input wire logic rst, // Async reset, high
	input wire logic fetch_ready, // Decoder takes a byte
	output logic fetch_valid, // Byte offered
	output logic [7:0] fetch_byte // Offered byte
);
	logic [7:0] q [$]; // Bytes still to offer
	int gap; // Idle clocks after each taken byte
	int wait_n;
	initial begin
		fetch_valid = 1'b0;
		fetch_byte = 8'h00;
		gap = 0;
		wait_n = 0;
	end
	// Hold a byte until taken; idle bus toggles so stale data never matches
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			fetch_valid <= 1'b0;
			wait_n = 0;
		end else begin
			if (fetch_valid && fetch_ready) begin
				void'(q.pop_front());
				wait_n = gap;
			end
			if (wait_n == 0 && q.size() > 0) begin
				fetch_valid <= 1'b1;
				fetch_byte <= q[0];
			end else begin
				wait_n = (wait_n > 0) ? wait_n - 1 : 0;
				fetch_valid <= 1'b0;
				fetch_byte <= ~fetch_byte;
			end
		end
	end
endmodule

/* verification/testbench.sv */
/*
 Self-checking bench for the decoder, fed by the fetch model.
 Assumes the decoder, its checker and the fetch model are compiled.
*/
`timescale 1ns/100ps
module testbench;
	logic core_clk, rst, op32, flag_of, flag_sf, flag_pf;
	logic fetch_valid, fetch_ready, done, move_en, illegal;
	logic [7:0] fetch_byte, modrm;
	logic [4:0] div_extra;
	logic [3:0] op_class;
	logic [31:0] disp, imm;
	logic [5:0] flags_mod, flags_undef;
	int n_errors, total_checks, cyc, last_take;
	cmd_decoder #(.CYC_SWAP_QUAD(6'h0B)) cmd_decoder_i (.core_clk(core_clk),
		.rst(rst), .fetch_valid(fetch_valid), .fetch_byte(fetch_byte),
		.op32(op32), .flag_of(flag_of), .flag_sf(flag_sf),
		.flag_pf(flag_pf), .div_extra(div_extra), .fetch_ready(fetch_ready),
		.done(done), .op_class(op_class), .move_en(move_en),
		.illegal(illegal), .modrm(modrm), .disp(disp), .imm(imm),
		.flags_mod(flags_mod), .flags_undef(flags_undef));
	cmd_fetch_model cmd_fetch_model_i (.core_clk(core_clk), .rst(rst),
		.fetch_ready(fetch_ready), .fetch_valid(fetch_valid),
		.fetch_byte(fetch_byte));
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// Stamp the cycle of every byte taken
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (fetch_valid === 1'b1 && fetch_ready === 1'b1) begin
			last_take <= cyc;
		end
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Offer n bytes, wait for done, judge latency, class and move
	task automatic exec(input logic [63:0] b, input int n,
		input logic [3:0] cls, input int ncyc, input logic mv);
		int k;
		for (int i = n - 1; i >= 0; i--) begin
			cmd_fetch_model_i.q.push_back(b[8*i +: 8]);
		end
		k = 0;
		do begin
			@(posedge core_clk);
			#1;
			k++;
		end while (done !== 1'b1 && k < 200);
		if (k >= 200) begin
			n_errors++;
			test_done();
		end
		chk(32'(cyc - last_take - 1), 32'(ncyc));
		chk(32'(op_class), 32'(cls));
		chk(32'(move_en), 32'(mv));
	endtask
	task automatic t_cmov();
		logic [7:0] ops [6];
		logic v;
		int op;
		ops = '{8'h40, 8'h41, 8'h4A, 8'h4B, 8'h48, 8'h49};
		for (int i = 0; i < 12; i++) begin
			op = i / 2;
			v = i[0];
			@(posedge core_clk);
			flag_of <= (op < 2) ? v : ~v;
			flag_pf <= (op == 2 || op == 3) ? v : ~v;
			flag_sf <= (op > 3) ? v : ~v;
			exec({8'h0F, ops[op], 8'hC0}, 3, 4'(op + 1), 1, v ^ op[0]);
			chk(32'(modrm), 32'hC0);
		end
		$display("t_cmov finished");
	endtask
	task automatic t_swap();
		exec(24'h0FB1C8, 3, 4'h7, 11, 1'b0);
		cmd_fetch_model_i.gap = 2;
		exec(32'h0FB045F0, 4, 4'h7, 11, 1'b0);
		cmd_fetch_model_i.gap = 0;
		chk(disp, 32'hFFFFFFF0);
		chk(32'(flags_mod), 32'h3F);
		// Index byte with base 101 and no mode adds a 4-byte displacement
		exec(64'h0F4B042578563412, 8, 4'h4, 1, ~flag_pf);
		chk(disp, 32'h12345678);
		exec(24'h0FC708, 3, 4'h8, 11, 1'b0);
		chk(32'(illegal), 32'h0);
		exec(24'h0FC7C8, 3, 4'h0, 1, 1'b0);
		chk(32'(illegal), 32'h1);
		exec(24'h0FC710, 3, 4'h0, 1, 1'b0);
		chk(32'(illegal), 32'h1);
		$display("t_swap finished");
	endtask
	task automatic t_short();
		logic [7:0] ops [4];
		ops = '{8'h99, 8'h98, 8'h27, 8'h2F};
		for (int i = 0; i < 4; i++) begin
			exec({40'h0, ops[i]}, 1, 4'(i + 9), (i < 2) ? 2 : 9, 1'b0);
		end
		for (int i = 0; i < 8; i++) begin
			exec({40'h0, 8'(8'h48 + i)}, 1, 4'hD, 1, 1'b0);
		end
		exec(16'hFEC8, 2, 4'hD, 1, 1'b0);
		exec(16'hFF08, 2, 4'hD, 1, 1'b0);
		chk(32'(flags_mod), 32'h3E);
		$display("t_short finished");
	endtask
	task automatic t_div();
		logic [7:0] ops [5];
		logic [4:0] ext [5];
		int n [5];
		ops = '{8'hF6, 8'hF6, 8'hF7, 8'hF7, 8'hF7};
		ext = '{5'h00, 5'h1F, 5'h1F, 5'h1F, 5'h05};
		n = '{13, 17, 25, 41, 18};
		for (int i = 0; i < 5; i++) begin
			@(posedge core_clk);
			div_extra <= ext[i];
			op32 <= (i > 2);
			exec({32'h0, ops[i], 8'hF0}, 2, 4'hE, n[i], 1'b0);
			chk(32'(flags_undef), 32'h3E);
		end
		exec(48'hF7C078563412, 6, 4'hF, 1, 1'b0);
		chk(imm, 32'h12345678);
		@(posedge core_clk);
		op32 <= 1'b0;
		exec(32'hF7C03412, 4, 4'hF, 1, 1'b0);
		chk(imm, 32'h00001234);
		exec(24'hF6C0AB, 3, 4'hF, 1, 1'b0);
		chk(imm, 32'h000000AB);
		exec(40'h0F48863412, 5, 4'h5, 1, flag_sf);
		chk(disp, 32'h00001234);
		$display("t_div finished");
	endtask
	// Abort a long divide by reset, then decode again
	task automatic t_reset();
		cmd_fetch_model_i.q.push_back(8'hF6);
		cmd_fetch_model_i.q.push_back(8'hF0);
		repeat (6) @(posedge core_clk);
		rst <= 1'b1;
		@(posedge core_clk);
		#1;
		chk(32'({fetch_ready, done, op_class}), 32'h0);
		@(posedge core_clk);
		rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		exec(8'h98, 1, 4'hA, 2, 1'b0);
		$display("t_reset finished");
	endtask
	initial begin
		rst = 1'b1;
		op32 = 1'b1;
		flag_of = 1'b0;
		flag_sf = 1'b0;
		flag_pf = 1'b0;
		div_extra = 5'h00;
		n_errors = 0;
		total_checks = 0;
		cyc = 0;
		last_take = 0;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		t_cmov();
		t_swap();
		t_short();
		t_div();
		t_reset();
		test_done();
	end
endmodule
bind cmd_decoder cmd_decoder_chk #(.CYC_SWAP_QUAD(CYC_SWAP_QUAD)) chk_i (
	.core_clk(core_clk), .rst(rst), .fetch_valid(fetch_valid),
	.fetch_byte(fetch_byte), .op32(op32), .flag_of(flag_of),
	.flag_sf(flag_sf), .flag_pf(flag_pf), .div_extra(div_extra),
	.fetch_ready(fetch_ready), .done(done), .op_class(op_class),
	.move_en(move_en), .illegal(illegal), .modrm(modrm), .disp(disp),
	.imm(imm), .flags_mod(flags_mod), .flags_undef(flags_undef));
